// ### hdl/mra_top.v
/*
 Mode-register access of a low-power DDR2 memory: decodes register read
 and write commands, serves temperature status and calibration patterns,
 and starts auto-initialization on a reset write. Assumes the controller
 keeps its spacing and NOP periods; CA inputs are synchronous to REF_CLK,
 with the falling-edge half presented as a separate bus.
*/
`timescale 1ns/1ps
`include "mra_map.vh"

module mra_top #(
   parameter DQ_W     = 16,
   parameter RD_LAT   = 3,
   parameter WR_PER   = 5,
   parameter TSI_CYC  = `MRA_TSI_MS * `MRA_CLK_MHZ * 1000,
   parameter INIT_CYC = `MRA_INIT_US * `MRA_CLK_MHZ
) (
   input  wire            REF_CLK,
   input  wire            NRST,
   input  wire            CKE,
   input  wire            CS_N,
   input  wire [9:0]      CA_RISE,
   input  wire [9:0]      CA_FALL,
   input  wire            BANKS_ACTIVE,
   input  wire            LP_EXIT,
   input  wire [2:0]      SENSOR_CODE,
   output reg  [DQ_W-1:0] DQ_OUT,
   output reg             DQ_OE_N,
   output reg             DQS_OUT,
   output reg             DQS_OE_N,
   output reg             INIT_BUSY,
   output reg             IDLE,
   output reg  [7:0]      CFG1,
   output reg  [7:0]      CFG2
);

   localparam LANES = DQ_W / 8;

   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_READ  = 4'h2;
   localparam [3:0] ST_WRITE = 4'h4;
   localparam [3:0] ST_INIT  = 4'h8;

   // =========================================================
   // declarations
   reg  [3:0]        state;
   reg  [3:0]        next_state;
   reg  [31:0]       count;
   reg  [31:0]       next_count;
   reg  [7:0]        rd_addr;
   reg  [3:0]        lat;
   reg               start;
   wire [4*DQ_W-1:0] beats;
   reg  [3:0]        pat;
   reg  [7:0]        rd_val;
   reg               was_active;
   wire [2:0]        temp_status;
   wire [DQ_W-1:0]   bo_dq;
   wire              bo_oe_n;
   wire              bo_dqs;
   wire              bo_busy;
   wire              cmd_live;
   wire              is_mrr;
   wire              is_mrw;
   wire [7:0]        addr;
   wire [7:0]        wdata;
   wire              wr_ok;
   wire              rd_take;
   wire              read_done;
   wire              is_cal;

   // =========================================================
   // command decode
   assign cmd_live = CKE && !CS_N;
   assign is_mrr = cmd_live && CA_RISE[3:0] == `MRA_CMD_MRR;
   assign is_mrw = cmd_live && CA_RISE[3:0] == `MRA_CMD_MRW;
   assign addr   = {CA_FALL[1:0], CA_RISE[9:4]};
   assign wdata  = CA_FALL[9:2];
   // writes with an open bank are dropped, not queued
   assign wr_ok   = is_mrw && !BANKS_ACTIVE;
   assign rd_take = state == ST_IDLE && is_mrr;

   // =========================================================
   // sub-blocks
   mra_temp_sampler #(
      .INTERVAL     (TSI_CYC)
   ) u_temp (
      .clk          (REF_CLK),
      .nrst         (NRST),
      .force_sample (LP_EXIT),
      .sensor_code  (SENSOR_CODE),
      .temp_status  (temp_status)
   );

   mra_burst_drive #(
      .DQ_W    (DQ_W)
   ) u_burst (
      .clk     (REF_CLK),
      .nrst    (NRST),
      .start   (start),
      .beats   (beats),
      .dq_out  (bo_dq),
      .dq_oe_n (bo_oe_n),
      .dqs_out (bo_dqs),
      .busy    (bo_busy)
   );

   // =========================================================
   // read data selection
   always @* begin
      pat    = 4'h0;
      rd_val = 8'h00;
      case (rd_addr)
         `MRA_ADDR_CALA: pat = `MRA_PAT_A;
         `MRA_ADDR_CALB: pat = `MRA_PAT_B;
         `MRA_ADDR_TEMP: rd_val = {5'h00, temp_status};
         `MRA_ADDR_CFG1: rd_val = CFG1;
         `MRA_ADDR_CFG2: rd_val = CFG2;
         default:        rd_val = 8'h00;
      endcase
   end

   // =========================================================
   // beat assembly: beat b, byte lane l
   // calibration copies the pattern bit onto every lane bit;
   // ordinary reads carry the register in lane 0 of beat 0 only
   assign is_cal = rd_addr == `MRA_ADDR_CALA ||
                   rd_addr == `MRA_ADDR_CALB;

   genvar b;
   genvar l;
   generate
      for (b = 0; b < 4; b = b + 1) begin : g_beat
         for (l = 0; l < LANES; l = l + 1) begin : g_lane
            wire [7:0] ord_byte;
            if (b == 0 && l == 0) begin : g_reg
               assign ord_byte = rd_val;
            end else begin : g_zero
               assign ord_byte = 8'h00;
            end
            assign beats[b*DQ_W+l*8 +: 8] = is_cal ? {8{pat[b]}} :
                                                     ord_byte;
         end
      end
   endgenerate

   // =========================================================
   // command state machine
   // burst fully out and nothing still queued for it;
   // start and lat cover the gap before the driver turns busy
   assign read_done = count >= `MRA_RD_PER - 32'd1 && !bo_busy &&
                      !start && lat == 4'h0;

   always @* begin
      next_state = state;
      next_count = count;
      case (state)
         ST_IDLE: begin
            if (is_mrr) begin
               next_state = ST_READ;
               next_count = 32'h0;
            end else if (wr_ok) begin
               next_count = 32'h0;
               if (addr == `MRA_ADDR_RESET)
                  next_state = ST_INIT;
               else
                  next_state = ST_WRITE;
            end
         end
         ST_READ: begin
            // two-clock command period, then wait for burst end
            next_count = count + 32'h1;
            if (read_done)
               next_state = ST_IDLE;
         end
         ST_WRITE: begin
            next_count = count + 32'h1;
            if (count >= WR_PER - 1)
               next_state = ST_IDLE;
         end
         ST_INIT: begin
            next_count = count + 32'h1;
            if (count >= INIT_CYC - 1)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
            next_count = 32'h0;
         end
      endcase
   end

   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state      <= ST_IDLE;
         count      <= 32'h0;
         rd_addr    <= 8'h00;
         lat        <= 4'h0;
         start      <= 1'b0;
         was_active <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         start <= 1'b0;
         if (rd_take) begin
            rd_addr    <= addr;
            lat        <= RD_LAT[3:0];
            was_active <= BANKS_ACTIVE;
         end else if (lat != 4'h0) begin
            lat <= lat - 4'h1;
            if (lat == 4'h1)
               start <= 1'b1;
         end
      end
   end

   // =========================================================
   // mode registers; unmapped or read-only targets ignored
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CFG1 <= `MRA_CFG1_RST;
         CFG2 <= `MRA_CFG2_RST;
      end else if (state == ST_INIT) begin
         CFG1 <= `MRA_CFG1_RST;
         CFG2 <= `MRA_CFG2_RST;
      end else if (state == ST_IDLE && wr_ok) begin
         case (addr)
            `MRA_ADDR_CFG1: CFG1 <= wdata;
            `MRA_ADDR_CFG2: CFG2 <= wdata;
            default:        CFG1 <= CFG1;
         endcase
      end
   end

   // =========================================================
   // registered outputs
   // one stage after the burst driver; strobe enable
   // follows data enable so both release together
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         DQ_OUT    <= {DQ_W{1'b0}};
         DQ_OE_N   <= 1'b1;
         DQS_OUT   <= 1'b0;
         DQS_OE_N  <= 1'b1;
         INIT_BUSY <= 1'b0;
         IDLE      <= 1'b1;
      end else begin
         DQ_OUT    <= bo_dq;
         DQ_OE_N   <= bo_oe_n;
         DQS_OUT   <= bo_dqs;
         DQS_OE_N  <= bo_oe_n;
         INIT_BUSY <= next_state == ST_INIT;
         IDLE      <= next_state == ST_IDLE;
      end
   end

endmodule

// ### hdl/mra_map.vh
/*
 Register map, command codes and timing figures for the mode-register
 access block. Included by every design file of the block.
*/
`ifndef MRA_MAP_VH
`define MRA_MAP_VH

// =========================================================
// command decode (rising-edge CA bits)
`define MRA_CMD_MRW      4'h0
`define MRA_CMD_MRR      4'h8

// =========================================================
// register addresses
`define MRA_ADDR_TEMP    8'h04
`define MRA_ADDR_CALA    8'h20
`define MRA_ADDR_CALB    8'h28
`define MRA_ADDR_RESET   8'h3f
`define MRA_ADDR_CFG1    8'h01
`define MRA_ADDR_CFG2    8'h02

// =========================================================
// reset values of writable registers and of the read-only temperature status
`define MRA_CFG1_RST     8'h00
`define MRA_CFG2_RST     8'h00
`define MRA_TEMP_RST     3'h3

// =========================================================
// calibration patterns, beat 0 in bit 0
`define MRA_PAT_A        4'h5
`define MRA_PAT_B        4'hc

// =========================================================
// field and timing figures
`define MRA_TEMP_HOT     3'h3
`define MRA_BURST_BEATS  3'h4
`define MRA_RD_PER       32'd2
`define MRA_TSI_MS       32
`define MRA_CLK_MHZ      125
`define MRA_INIT_US      10

`endif

// ### hdl/mra_temp_sampler.v
/*
 Periodic temperature sampler: latches the sensor code into the
 three-bit status field on every interval tick. Assumes the sensor
 input is synchronous to the clock.
*/
`timescale 1ns/1ps
`include "mra_map.vh"

module mra_temp_sampler #(
   parameter INTERVAL = 32'd4000000
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       force_sample,
   input  wire [2:0] sensor_code,
   output reg  [2:0] temp_status
);

   reg [31:0] count;

   // =========================================================
   // interval timer, restarted by a forced sample
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count       <= 32'h0;
         temp_status <= `MRA_TEMP_RST;
      end else if (force_sample || count >= INTERVAL - 32'd1) begin
         count       <= 32'h0;
         temp_status <= sensor_code;
      end else begin
         count <= count + 32'h1;
      end
   end

endmodule

// ### hdl/mra_burst_drive.v
/*
 Read-burst driver: shifts four beats onto the data bus with a toggling
 strobe. Assumes the caller loads one beat set per burst.
*/
`timescale 1ns/1ps
`include "mra_map.vh"

module mra_burst_drive #(
   parameter DQ_W = 16
) (
   input  wire              clk,
   input  wire              nrst,
   input  wire              start,
   input  wire [4*DQ_W-1:0] beats,
   output reg  [DQ_W-1:0]   dq_out,
   output reg               dq_oe_n,
   output reg               dqs_out,
   output reg               busy
);

   reg [4*DQ_W-1:0] shift;
   reg [2:0]        left;

   // =========================================================
   // beats leave low word first; burst never cut short
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift   <= {4*DQ_W{1'b0}};
         left    <= 3'h0;
         dq_out  <= {DQ_W{1'b0}};
         dq_oe_n <= 1'b1;
         dqs_out <= 1'b0;
         busy    <= 1'b0;
      end else if (start && !busy) begin
         shift   <= beats >> DQ_W;
         left    <= `MRA_BURST_BEATS - 3'h1;
         dq_out  <= beats[DQ_W-1:0];
         dq_oe_n <= 1'b0;
         dqs_out <= 1'b1;
         busy    <= 1'b1;
      end else if (left != 3'h0) begin
         shift   <= shift >> DQ_W;
         left    <= left - 3'h1;
         dq_out  <= shift[DQ_W-1:0];
         dqs_out <= ~dqs_out;
      end else begin
         dq_out  <= {DQ_W{1'b0}};
         dq_oe_n <= 1'b1;
         dqs_out <= 1'b0;
         busy    <= 1'b0;
      end
   end

endmodule

// ### bench/mra_checker.sv
/* Checker for mra_top: burst shape, read latency, write effects and
   reset-write init. Bound to every mra_top; sees only its ports. */
`timescale 1ns/1ps
module mra_checker #(
   parameter RD_LAT   = 3,
   parameter INIT_CYC = 20
) (
   input wire       REF_CLK,
   input wire       NRST,
   input wire       CKE,
   input wire       CS_N,
   input wire [9:0] CA_RISE,
   input wire [9:0] CA_FALL,
   input wire       BANKS_ACTIVE,
   input wire       DQ_OE_N,
   input wire       DQS_OUT,
   input wire       DQS_OE_N,
   input wire       INIT_BUSY,
   input wire       IDLE,
   input wire [7:0] CFG1,
   input wire [7:0] CFG2
);
   localparam int R2 = RD_LAT + 2;
   localparam int R3 = RD_LAT + 3;
   wire        take = CKE && !CS_N && IDLE && !INIT_BUSY;
   wire        rd   = take && CA_RISE[3:0] == 4'h8;
   wire        wa   = take && CA_RISE[3:0] == 4'h0;
   wire        wr   = wa && !BANKS_ACTIVE;
   wire [7:0]  adr  = {CA_FALL[1:0], CA_RISE[9:4]};
   reg  [7:0]  wdat;
   reg  [31:0] init_cnt;
   // ==========
   // write data and init length tracking
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         wdat     <= 8'h00;
         init_cnt <= 32'h0;
      end else begin
         wdat     <= wr ? CA_FALL[9:2] : wdat;
         init_cnt <= INIT_BUSY ? init_cnt + 32'h1 : 32'h0;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   sequence strobe_seq;
      DQS_OUT ##1 !DQS_OUT ##1 DQS_OUT ##1 !DQS_OUT;
   endsequence
   sequence four_beats;
      !DQ_OE_N [*4] ##1 DQ_OE_N;
   endsequence
   a_burst_len: assert property ($fell(DQ_OE_N) |-> four_beats)
      else $error("read burst not four beats");
   a_strobe_beats: assert property ($fell(DQ_OE_N) |-> strobe_seq)
      else $error("strobe not toggling per beat");
   a_strobe_oe: assert property (DQS_OE_N == DQ_OE_N)
      else $error("strobe enable differs from data enable");
   a_read_latency: assert property (
      rd |-> ##[R2:R3] $fell(DQ_OE_N))
      else $error("read data not on time");
   a_write_busy: assert property (
      wr && adr != 8'h3f |-> ##2 !IDLE [*3])
      else $error("write period too short");
   a_cfg_write: assert property (
      wr && adr == 8'h01 |-> ##[1:2] CFG1 == wdat)
      else $error("register write lost");
   a_write_kept: assert property (
      wa && (BANKS_ACTIVE || adr == 8'h04) |=> $stable({CFG1, CFG2}) [*2])
      else $error("refused write changed registers");
   a_reset_init: assert property (
      wr && adr == 8'h3f |-> ##[1:2] INIT_BUSY)
      else $error("reset write did not start init");
   a_init_default: assert property (
      INIT_BUSY && $past(INIT_BUSY) |-> {CFG1, CFG2} == 16'h0)
      else $error("registers not default during init");
   a_init_length: assert property (
      $fell(INIT_BUSY) |-> init_cnt == INIT_CYC)
      else $error("init period wrong length");
endmodule
bind mra_top mra_checker #(.RD_LAT(RD_LAT), .INIT_CYC(INIT_CYC)) i_mra_checker (
   .REF_CLK(REF_CLK), .NRST(NRST), .CKE(CKE), .CS_N(CS_N),
   .CA_RISE(CA_RISE), .CA_FALL(CA_FALL), .BANKS_ACTIVE(BANKS_ACTIVE),
   .DQ_OE_N(DQ_OE_N), .DQS_OUT(DQS_OUT), .DQS_OE_N(DQS_OE_N),
   .INIT_BUSY(INIT_BUSY), .IDLE(IDLE), .CFG1(CFG1), .CFG2(CFG2));

// ### bench/mra_ctrl_model.sv
/* Controller model: issues register commands on the command bus.
   Assumes calls start just after a clock edge. */
`timescale 1ns/1ps
module mra_ctrl_model (
   input  wire       clk,
   input  wire       idle,
   input  wire       init_busy,
   output reg        cke = 1'b1,
   output reg        cs_n = 1'b1,
   output reg  [9:0] ca_rise = 10'h155,
   output reg  [9:0] ca_fall = 10'h2aa
);
   // ==========
   // wait until idle, then gap clocks, then one command and a nop
   task automatic send(input [3:0] op, input [7:0] adr, input [7:0] dat,
                       input integer gap);
      integer n;
      begin
         n = 0;
         while ((!idle || init_busy) && n < 100) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         repeat (gap) @(posedge clk);
         #1;
         cs_n    = 1'b0;
         ca_rise = {adr[5:0], op};
         ca_fall = {dat, adr[7:6]};
         @(posedge clk);
         #1;
         cs_n    = 1'b1;
         ca_rise = ~ca_rise;
         ca_fall = ~ca_fall;
      end
   endtask
endmodule

// ### bench/mra_top_tb.sv
/* Bench for mra_top: commands go through the controller model; bursts,
   writes, temperature and reset write are checked. */
`timescale 1ns/1ps
module mra_top_tb;
   reg         ref_clk, nrst, banks_active, lp_exit;
   reg  [2:0]  sensor_code;
   wire        cke, cs_n, dq_oe_n, dqs_out, dqs_oe_n, init_busy, idle;
   wire [9:0]  ca_rise, ca_fall;
   wire [31:0] dq_out;
   wire [7:0]  cfg1, cfg2;
   reg [127:0] b;
   integer     error_cnt, cmp_count, n;
   mra_ctrl_model i_mra_ctrl_model (.clk(ref_clk), .idle(idle),
      .init_busy(init_busy), .cke(cke), .cs_n(cs_n), .ca_rise(ca_rise),
      .ca_fall(ca_fall));
   mra_top #(.DQ_W(32), .TSI_CYC(100), .INIT_CYC(20)) i_mra_top (
      .REF_CLK(ref_clk), .NRST(nrst), .CKE(cke), .CS_N(cs_n),
      .CA_RISE(ca_rise), .CA_FALL(ca_fall), .BANKS_ACTIVE(banks_active),
      .LP_EXIT(lp_exit), .SENSOR_CODE(sensor_code), .DQ_OUT(dq_out),
      .DQ_OE_N(dq_oe_n), .DQS_OUT(dqs_out), .DQS_OE_N(dqs_oe_n),
      .INIT_BUSY(init_busy), .IDLE(idle), .CFG1(cfg1), .CFG2(cfg2));
   // ==========
   // helpers
   task chk(input string nm, input [127:0] exp, input [127:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task tick(input integer k);
      begin
         repeat (k) @(posedge ref_clk);
         #1;
      end
   endtask
   task rd(input [7:0] adr);
      integer k;
      begin
         i_mra_ctrl_model.send(4'h8, adr, 8'h00, 0);
         n = 0;
         while (dq_oe_n !== 1'b0 && n < 12) begin
            tick(1);
            n = n + 1;
         end
         for (k = 0; k < 4; k = k + 1) begin
            b[32*k +: 32] = dq_out;
            chk("strobe", !k[0], dqs_out);
            tick(1);
         end
         chk("burst end", 1'b1, dq_oe_n);
      end
   endtask
   // ==========
   // scenarios
   task t_temp;
      begin
         chk("reset state", 20'hb0000, {idle, init_busy, dq_oe_n, dqs_oe_n,
             cfg1, cfg2});
         rd(8'h04);
         chk("temp reset", 3'h3, b[2:0]);
         tick(110);
         rd(8'h04);
         chk("temp sample", 3'h5, b[2:0]);
         sensor_code = 3'h2;
         lp_exit = 1'b1;
         tick(1);
         lp_exit = 1'b0;
         rd(8'h04);
         chk("temp exit", 3'h2, b[2:0]);
      end
   endtask
   task t_cal;
      begin
         rd(8'h20);
         chk("pattern a", {2{32'h0, 32'hffffffff}}, b);
         rd(8'h28);
         chk("pattern b", {{64{1'b1}}, 64'h0}, b);
      end
   endtask
   task t_write;
      begin
         i_mra_ctrl_model.send(4'h0, 8'h01, 8'ha5, 0);
         i_mra_ctrl_model.send(4'h0, 8'h02, 8'h3c, 3);
         tick(3);
         chk("cfg regs", 16'ha53c, {cfg1, cfg2});
         rd(8'h01);
         chk("read cfg1", 32'ha5, b[31:0]);
      end
   endtask
   task t_refuse;
      begin
         banks_active = 1'b1;
         i_mra_ctrl_model.send(4'h0, 8'h01, 8'h11, 0);
         tick(3);
         chk("blocked write", 8'ha5, cfg1);
         rd(8'h02);
         chk("read active", 32'h3c, b[31:0]);
         banks_active = 1'b0;
         i_mra_ctrl_model.send(4'h0, 8'h04, 8'hff, 0);
         tick(6);
         chk("ro write", 16'ha53c, {cfg1, cfg2});
      end
   endtask
   task t_reset_wr;
      begin
         i_mra_ctrl_model.send(4'h0, 8'h3f, 8'h00, 0);
         tick(1);
         chk("init busy", 1'b1, init_busy);
         n = 0;
         while (init_busy === 1'b1 && n < 40) begin
            tick(1);
            n = n + 1;
         end
         chk("cfg default", 16'h0, {cfg1, cfg2});
         rd(8'h20);
         chk("after init", {2{32'h0, 32'hffffffff}}, b);
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d compares %0d", error_cnt, cmp_count);
         if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // ==========
   // clock, watchdog, main sequence
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      error_cnt = error_cnt + 1;
      give_verdict;
   end
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      nrst = 1'b0;
      banks_active = 1'b0;
      lp_exit = 1'b0;
      sensor_code = 3'h5;
      tick(2);
      nrst = 1'b1;
      t_temp;
      t_cal;
      t_write;
      t_refuse;
      t_reset_wr;
      give_verdict;
   end
endmodule
